// *** pkg/sls_pkg.sv ***
// constants, types and field layouts for the serial link supervisor
// Summary of operation
// - reply delayed by wait time plus check time
// - character: start, 7/8 data, parity, 1/2 stop
// - fast instructions checked in under 20 ms
// - nonvolatile frequency access checked under 40 ms
// - errors beyond retry limit trip, output off
// - retry limit 9999 gives alarm only
// - alarm pin needs function code 98/198
// - signal loss trips, shuts output, raises alarm
// - check interval 9999 disables loss checking
// - interval zero trips on entering network mode
// - interval 0.1 to 999.8 s enables loss detection
// - any frame clears the loss counter
// - loss checking starts at first frame
// - errored requests get a nak reply, not acted on
// - device only replies, never sends unprompted
// - mode read H7B returns 0, 1 or 2
// - mode write HFB selects network, external, panel
// - wait 9999 takes frame delay field times 10 ms
package sls_pkg;
	// clock and time base
	localparam int CLK_PERIOD_PS = 4000;
	localparam int MS_PS = 1000000000;
	localparam int MS_CYC = MS_PS / CLK_PERIOD_PS;
	localparam logic [19:0] WAIT_UNIT_MS = 20'h0000a;
	localparam logic [6:0] LOSS_UNIT_MS = 7'h64;
	localparam logic [19:0] CHK_FAST_MS = 20'h00013;
	localparam logic [19:0] CHK_NV_MS = 20'h00027;
	// special setting values
	localparam logic [15:0] SET_OFF = 16'h270f;
	localparam logic [15:0] CHK_ZERO = 16'h0000;
	localparam logic [7:0] TERM_POS = 8'h62;
	localparam logic [7:0] TERM_NEG = 8'hc6;
	// instruction codes and mode data
	localparam logic [7:0] INS_MODE_RD = 8'h7b;
	localparam logic [7:0] INS_MODE_WR = 8'hfb;
	localparam logic [15:0] MCODE_NET = 16'h0000;
	localparam logic [15:0] MCODE_EXT = 16'h0001;
	localparam logic [15:0] MCODE_PANEL = 16'h0002;
	// register byte addresses
	localparam logic [7:0] A_CFG = 8'h00;
	localparam logic [7:0] A_RETRY = 8'h04;
	localparam logic [7:0] A_CHECK = 8'h08;
	localparam logic [7:0] A_WAIT = 8'h0c;
	localparam logic [7:0] A_MODE = 8'h10;
	localparam logic [7:0] A_STATUS = 8'h14;
	localparam logic [7:0] A_CLEAR = 8'h18;
	// reset values
	localparam logic [15:0] RETRY_RST = 16'h0000;
	localparam logic [15:0] CHECK_RST = 16'h270f;
	localparam logic [15:0] WAIT_RST = 16'h270f;
	localparam logic [7:0] TERM_RST = 8'h00;
	// field positions
	localparam int CFG_FMT_LSB = 0;
	localparam int CFG_TERM_LSB = 8;
	localparam int ST_TRIP = 0;
	localparam int ST_ALARM = 1;
	localparam int ST_BUSY = 2;
	localparam int ST_ARMED = 3;
	localparam int ST_ERR_LSB = 16;
	localparam int CLR_BIT = 0;

	typedef enum logic [2:0] {
		MODE_NET, MODE_EXT, MODE_EXT_JOG, MODE_PANEL, MODE_COMBINED, MODE_PANEL_JOG
	} sls_mode_e;

	typedef struct packed {
		logic stop2;
		logic parity_odd;
		logic parity_en;
		logic data8;
	} sls_fmt_s;

	typedef struct packed {
		logic [7:0] instr;
		logic [15:0] data;
		logic [3:0] delay;
		logic nv;
	} sls_frame_s;

	typedef struct packed {
		logic nak;
		logic [7:0] instr;
		logic [15:0] data;
	} sls_reply_s;
endpackage : sls_pkg

// *** verilog/sls_tick.sv ***
// millisecond enable pulse divided from the system clock
module sls_tick #(
	parameter int TICK_CYC = sls_pkg::MS_CYC
) (
	input wire logic clk,
	input wire logic rst,
	output logic ms_tick
);
	import sls_pkg::*;

	typedef struct packed {
		logic [17:0] cnt;
		logic tick;
	} sls_tick_s;

	sls_tick_s s, next_s;

	// free running divider, one pulse per wrap
	always_comb begin
		next_s = s;
		next_s.tick = 1'b0;
		if (s.cnt == 18'(TICK_CYC - 1)) begin
			next_s.cnt = '0;
			next_s.tick = 1'b1;
		end else begin
			next_s.cnt = s.cnt + 18'h00001;
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign ms_tick = s.tick;
endmodule : sls_tick

// *** verilog/sls_delay.sv ***
// reply delay timer counted in millisecond ticks
module sls_delay (
	input wire logic clk,
	input wire logic rst,
	input wire logic ms_tick,
	input wire logic start,
	input wire logic [19:0] target,
	output logic done,
	output logic busy
);
	import sls_pkg::*;

	typedef struct packed {
		logic [19:0] cnt;
		logic [19:0] lim;
		logic run;
		logic done;
	} sls_delay_s;

	sls_delay_s s, next_s;

	// count whole ticks up to the latched limit
	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		if (start) begin
			next_s.cnt = '0;
			next_s.lim = target;
			next_s.run = 1'b1;
		end else if (s.run) begin
			if (s.cnt >= s.lim) begin
				next_s.run = 1'b0;
				next_s.done = 1'b1;
			end else if (ms_tick) begin
				next_s.cnt = s.cnt + 20'h00001;
			end
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign done = s.done;
	assign busy = s.run;
endmodule : sls_delay

// *** verilog/sls_top.sv ***
// serial link supervisor: reply timing, retry limit, signal loss, operation mode
module sls_top #(
	parameter int TICK_CYC = sls_pkg::MS_CYC
) (
	input wire logic clk,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// frames from the character receiver
	input wire logic frame_done,
	input wire logic frame_err,
	input wire sls_pkg::sls_frame_s frame,
	output logic frame_ready,
	// character format to the receiver and transmitter
	output sls_pkg::sls_fmt_s char_fmt,
	// reply request to the transmitter
	output logic reply_valid,
	output sls_pkg::sls_reply_s reply,
	// drive side
	input wire logic drive_reset_input,
	output logic link_fault_trip,
	output logic output_shutoff,
	output logic minor_alarm_output
);
	import sls_pkg::*;

	typedef struct packed {
		logic [31:0] prdata;
		sls_fmt_s fmt;
		logic [7:0] term_func;
		logic [15:0] retry;
		logic [15:0] check;
		logic [15:0] wait_set;
		sls_mode_e mode;
		logic was_net;
		logic armed;
		logic [6:0] loss_sub;
		logic [15:0] loss_cnt;
		logic [15:0] err_cnt;
		logic trip;
		logic alarm;
		logic term_pin;
		logic pend;
		sls_reply_s rep;
		logic rep_valid;
		logic rst_meta;
		logic rst_sync;
	} sls_state_s;

	sls_state_s s, next_s;

	logic ms_tick;
	logic dly_start;
	logic [19:0] dly_target;
	logic dly_done;
	logic dly_busy;

	// reply delay: waiting time plus data check time
	function automatic logic [19:0] reply_target(
		input logic [15:0] wait_set,
		input logic [3:0] fdelay,
		input logic nv
	);
		logic [19:0] w;
		logic [19:0] c;
		w = '0;
		c = '0;
		if (wait_set == SET_OFF) begin
			w = 20'(fdelay) * WAIT_UNIT_MS;
		end else begin
			w = 20'(wait_set) * WAIT_UNIT_MS;
		end
		c = nv ? CHK_NV_MS : CHK_FAST_MS;
		return w + c;
	endfunction : reply_target

	// operation mode as reported to the host
	function automatic logic [15:0] mode_code(input sls_mode_e m);
		logic [15:0] r;
		r = MCODE_PANEL;
		case (m)
			MODE_NET: r = MCODE_NET;
			MODE_EXT, MODE_EXT_JOG: r = MCODE_EXT;
			default: r = MCODE_PANEL;
		endcase
		return r;
	endfunction : mode_code

	// time base and reply timer
	sls_tick #(
		.TICK_CYC(TICK_CYC)
	) u_tick (
		.clk(clk),
		.rst(rst),
		.ms_tick(ms_tick)
	);

	sls_delay u_delay (
		.clk(clk),
		.rst(rst),
		.ms_tick(ms_tick),
		.start(dly_start),
		.target(dly_target),
		.done(dly_done),
		.busy(dly_busy)
	);

	// bus decode
	logic apb_setup;
	logic apb_wr;
	logic addr_hit;
	logic is_net;
	logic frame_any;
	logic take;
	logic [15:0] err_next;

	always_comb begin
		apb_setup = psel && !penable;
		apb_wr = psel && penable && pwrite;
		case (paddr)
			A_CFG, A_RETRY, A_CHECK, A_WAIT, A_MODE, A_STATUS, A_CLEAR: addr_hit = 1'b1;
			default: addr_hit = 1'b0;
		endcase
		is_net = (s.mode == MODE_NET);
		frame_any = frame_done || frame_err;
		take = frame_any && !s.pend;
		err_next = (s.err_cnt == 16'hffff) ? s.err_cnt : s.err_cnt + 16'h0001;
		dly_start = take;
		dly_target = reply_target(s.wait_set, frame.delay, frame.nv);
	end

	// next state
	always_comb begin
		next_s = s;
		next_s.rst_meta = drive_reset_input;
		next_s.rst_sync = s.rst_meta;
		next_s.rep_valid = 1'b0;
		next_s.was_net = is_net;

		// read data captured in setup, valid through the access phase
		if (apb_setup && !pwrite) begin
			case (paddr)
				A_CFG: begin
					next_s.prdata = '0;
					next_s.prdata[CFG_FMT_LSB +: 4] = s.fmt;
					next_s.prdata[CFG_TERM_LSB +: 8] = s.term_func;
				end
				A_RETRY: next_s.prdata = {16'h0000, s.retry};
				A_CHECK: next_s.prdata = {16'h0000, s.check};
				A_WAIT: next_s.prdata = {16'h0000, s.wait_set};
				A_MODE: next_s.prdata = {29'h0000000, s.mode};
				A_STATUS: begin
					next_s.prdata = '0;
					next_s.prdata[ST_TRIP] = s.trip;
					next_s.prdata[ST_ALARM] = s.alarm;
					next_s.prdata[ST_BUSY] = s.pend;
					next_s.prdata[ST_ARMED] = s.armed;
					next_s.prdata[ST_ERR_LSB +: 16] = s.err_cnt;
				end
				default: next_s.prdata = '0;
			endcase
		end

		// register writes
		if (apb_wr) begin
			case (paddr)
				A_CFG: begin
					next_s.fmt = pwdata[CFG_FMT_LSB +: 4];
					next_s.term_func = pwdata[CFG_TERM_LSB +: 8];
				end
				A_RETRY: next_s.retry = pwdata[15:0];
				A_CHECK: next_s.check = pwdata[15:0];
				A_WAIT: next_s.wait_set = pwdata[15:0];
				A_MODE: begin
					if (pwdata[2:0] <= 3'(MODE_PANEL_JOG)) begin
						next_s.mode = sls_mode_e'(pwdata[2:0]);
					end
				end
				A_CLEAR: begin
					if (pwdata[CLR_BIT]) begin
						next_s.trip = 1'b0;
						next_s.alarm = 1'b0;
						next_s.err_cnt = '0;
					end
				end
				default: ;
			endcase
		end

		// drive reset pin clears the fault state
		if (s.rst_sync) begin
			next_s.trip = 1'b0;
			next_s.alarm = 1'b0;
			next_s.err_cnt = '0;
		end

		// accept a request; errored ones are answered with nak only
		if (take) begin
			next_s.pend = 1'b1;
			next_s.rep.instr = frame.instr;
			next_s.rep.nak = frame_err;
			next_s.rep.data = '0;
			if (frame_err) begin
				next_s.rep.nak = 1'b1;
			end else if (frame.instr == INS_MODE_RD) begin
				next_s.rep.data = mode_code(s.mode);
			end else if (frame.instr == INS_MODE_WR) begin
				case (frame.data)
					MCODE_NET: next_s.mode = MODE_NET;
					MCODE_EXT: next_s.mode = MODE_EXT;
					MCODE_PANEL: next_s.mode = MODE_PANEL;
					default: next_s.rep.nak = 1'b1;
				endcase
			end
		end

		// reply leaves only after the timer ends
		if (dly_done && s.pend) begin
			next_s.pend = 1'b0;
			next_s.rep_valid = 1'b1;
		end

		// consecutive receive errors; a good frame resets the run
		if (frame_err) begin
			next_s.err_cnt = err_next;
			if (s.retry == SET_OFF) begin
				next_s.alarm = 1'b1;
			end else if (err_next > s.retry) begin
				next_s.trip = 1'b1;
				next_s.alarm = 1'b1;
			end
		end else if (frame_done) begin
			next_s.err_cnt = '0;
		end

		// loss checking armed by the first frame in network mode
		if (!is_net || !s.was_net) begin
			next_s.armed = 1'b0;
		end
		if (is_net && frame_any) begin
			next_s.armed = 1'b1;
		end

		// loss timer in 0.1 s steps, restarted by every frame
		if (frame_any || !s.armed) begin
			next_s.loss_sub = '0;
			next_s.loss_cnt = '0;
		end else if (ms_tick) begin
			if (s.loss_sub == LOSS_UNIT_MS - 7'h01) begin
				next_s.loss_sub = '0;
				if (s.loss_cnt != 16'hffff) begin
					next_s.loss_cnt = s.loss_cnt + 16'h0001;
				end
			end else begin
				next_s.loss_sub = s.loss_sub + 7'h01;
			end
		end

		// signal loss detection, disabled by the off value
		if (s.check != SET_OFF) begin
			if (s.check == CHK_ZERO) begin
				if (is_net) begin
					next_s.trip = 1'b1;
					next_s.alarm = 1'b1;
				end
			end else if (s.armed && !frame_any && s.loss_cnt >= s.check) begin
				next_s.trip = 1'b1;
				next_s.alarm = 1'b1;
			end
		end

		// alarm terminal only with its function code assigned
		case (s.term_func)
			TERM_POS: next_s.term_pin = next_s.alarm;
			TERM_NEG: next_s.term_pin = !next_s.alarm;
			default: next_s.term_pin = 1'b0;
		endcase
	end

	// state register
	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
			s.retry <= RETRY_RST;
			s.check <= CHECK_RST;
			s.wait_set <= WAIT_RST;
			s.term_func <= TERM_RST;
			s.mode <= MODE_EXT;
		end else begin
			s <= next_s;
		end
	end

	// outputs
	assign prdata = s.prdata;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_hit;
	assign frame_ready = !s.pend;
	assign char_fmt = s.fmt;
	assign reply_valid = s.rep_valid;
	assign reply = s.rep;
	assign link_fault_trip = s.trip;
	assign output_shutoff = s.trip;
	assign minor_alarm_output = s.term_pin;
endmodule : sls_top

// *** sim/sls_top_properties.sv ***
// port-level assertions for the serial link supervisor
module sls_top_properties #(
	parameter int TICK_CYC = sls_pkg::MS_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic frame_done,
	input wire logic frame_err,
	input wire logic frame_ready,
	input wire sls_pkg::sls_fmt_s char_fmt,
	input wire logic reply_valid,
	input wire logic link_fault_trip,
	input wire logic output_shutoff,
	input wire logic minor_alarm_output
);
	timeunit 1ns;
	timeprecision 1ps;
	import sls_pkg::*;
	localparam int MIN_AGE = 18 * TICK_CYC - 2;
	logic [3:0] wfmt;
	assign wfmt = pwdata[3:0];
	logic take;
	logic pend;
	int unsigned age;
	logic [7:0] term;
	assign take = (frame_done | frame_err) & frame_ready;
	// pending request, cycles since take, terminal function code
	always_ff @(posedge clk) begin
		if (rst) begin
			pend <= 1'b0;
			age <= 0;
			term <= 8'h00;
		end else begin
			pend <= take | (pend & ~reply_valid);
			age <= take ? 0 : age + 1;
			if (psel & penable & pwrite & (paddr == A_CFG)) term <= pwdata[15:8];
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	bus_ready_a: assert property (psel & penable |-> pready)
		else $error("access without ready");
	unmapped_err_a: assert property (psel & penable & (paddr > A_CLEAR) |-> pslverr)
		else $error("unmapped access not refused");
	fmt_load_a: assert property (psel & penable & pwrite & (paddr == A_CFG)
		|=> char_fmt == $past(wfmt)) else $error("character format not loaded");
	shutoff_trip_a: assert property (output_shutoff == link_fault_trip)
		else $error("shutoff differs from trip");
	reply_pulse_a: assert property (reply_valid |=> !reply_valid)
		else $error("reply longer than one cycle");
	reply_asked_a: assert property (reply_valid |-> pend)
		else $error("reply without request");
	reply_early_a: assert property (reply_valid |-> age >= MIN_AGE)
		else $error("reply too early");
	busy_take_a: assert property (take |=> !frame_ready [*8])
		else $error("ready while reply pending");
	ready_back_a: assert property (reply_valid |=> frame_ready)
		else $error("ready not restored");
	alarm_term_a: assert property ((term != TERM_POS) && (term != TERM_NEG)
		&& ($past(term) == term) |-> !minor_alarm_output) else $error("alarm on free pin");
	// main scenarios reached
	cover property (reply_valid);
	cover property ($rose(link_fault_trip));
	cover property ($rose(minor_alarm_output));
endmodule : sls_top_properties

bind sls_top sls_top_properties #(.TICK_CYC(TICK_CYC)) u_sls_top_properties (.clk, .rst,
	.psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .frame_done, .frame_err,
	.frame_ready, .char_fmt, .reply_valid, .link_fault_trip, .output_shutoff,
	.minor_alarm_output);

// *** sim/sls_host.sv ***
// host model: hands complete frames to the supervisor
module sls_host (
	input wire logic clk,
	output logic frame_done,
	output logic frame_err,
	output sls_pkg::sls_frame_s frame
);
	timeunit 1ns;
	timeprecision 1ps;
	import sls_pkg::*;
	initial begin
		frame_done = 1'b0;
		frame_err = 1'b0;
		frame = '0;
	end
	// one-cycle pulse; afterwards the frame lines stop showing the value
	task automatic send(input sls_frame_s f, input logic bad);
		@(posedge clk);
		frame_done <= ~bad;
		frame_err <= bad;
		frame <= f;
		@(posedge clk);
		frame_done <= 1'b0;
		frame_err <= 1'b0;
		frame <= ~f;
	endtask : send
endmodule : sls_host

// *** sim/sls_top_bench.sv ***
// self-checking bench for the serial link supervisor
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
	$display("[ERR] %0t mismatch", $time); end end
module sls_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import sls_pkg::*;
	localparam int T = 10;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic drive_reset_input = 1'b0;
	logic [31:0] prdata;
	logic pready, pslverr, frame_done, frame_err, frame_ready, reply_valid;
	logic link_fault_trip, output_shutoff, minor_alarm_output;
	sls_frame_s frame;
	sls_fmt_s char_fmt;
	sls_reply_s reply;
	sls_reply_s r;
	int err_count = 0;
	int comparisons = 0;
	int n;
	logic [31:0] q;
	logic e;
	always #2 clk = ~clk;
	sls_top #(.TICK_CYC(T)) u_sls_top (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .frame_done, .frame_err, .frame, .frame_ready, .char_fmt,
		.reply_valid, .reply, .drive_reset_input, .link_fault_trip, .output_shutoff,
		.minor_alarm_output);
	sls_host u_sls_host (.clk, .frame_done, .frame_err, .frame);
	// one apb transfer; q and e take the answer at the pready edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// frame out, cycles to reply counted in n
	task automatic xfer(input logic [7:0] i, input logic [15:0] d, input logic [3:0] dl,
		input logic nv, input logic bad);
		while (frame_ready !== 1'b1) @(negedge clk);
		u_sls_host.send(sls_frame_s'{i, d, dl, nv}, bad);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (reply_valid !== 1'b1);
		r = reply;
	endtask : xfer
	task automatic win(input int ms);
		`CHK(n >= (ms - 1) * T && n <= ms * T + 2, 1'b1)
	endtask : win
	// reset values, unmapped place, character format
	task automatic t_reset();
		apb(0, A_RETRY, 0);
		`CHK(q, 32'h0)
		apb(0, A_CHECK, 0);
		`CHK(q, 32'h0000270f)
		apb(0, A_WAIT, 0);
		`CHK(q, 32'h0000270f)
		apb(0, 8'h1c, 0);
		`CHK(e, 1'b1)
		apb(1, A_CFG, 32'h0000000b);
		@(negedge clk);
		`CHK(char_fmt, 4'hb)
	endtask : t_reset
	// reply delay from wait setting, frame field and check time
	task automatic t_reply();
		xfer(INS_MODE_RD, 16'h0, 4'h1, 1'b0, 1'b0);
		win(29);
		`CHK(r.data, MCODE_EXT)
		apb(1, A_WAIT, 0);
		xfer(INS_MODE_RD, 16'h0, 4'h7, 1'b0, 1'b0);
		win(19);
		xfer(INS_MODE_RD, 16'h0, 4'h0, 1'b1, 1'b0);
		win(39);
	endtask : t_reply
	// mode read for every mode, mode write for every code
	task automatic t_mode();
		logic [15:0] m;
		for (int i = 0; i < 6; i++) begin
			m = (i == 0) ? MCODE_NET : (i < 3) ? MCODE_EXT : MCODE_PANEL;
			apb(1, A_MODE, 32'(i));
			xfer(INS_MODE_RD, 16'h0, 4'h0, 1'b0, 1'b0);
			`CHK(r.data, m)
		end
		for (int i = 2; i >= 0; i--) begin
			xfer(INS_MODE_WR, 16'(i), 4'h0, 1'b0, 1'b0);
			apb(0, A_MODE, 0);
			`CHK(q, (i == 2) ? 32'h3 : 32'(i))
		end
		xfer(INS_MODE_WR, 16'h0005, 4'h0, 1'b0, 1'b0);
		`CHK(r.nak, 1'b1)
	endtask : t_mode
	// consecutive errors beyond the limit trip; good frame restarts count
	task automatic t_retry();
		apb(1, A_RETRY, 1);
		apb(1, A_CFG, 32'h00006200);
		xfer(INS_MODE_WR, MCODE_PANEL, 4'h0, 1'b0, 1'b1);
		`CHK(r.nak, 1'b1)
		`CHK(link_fault_trip, 1'b0)
		apb(0, A_MODE, 0);
		`CHK(q, 32'h0)
		xfer(INS_MODE_RD, 16'h0, 4'h0, 1'b0, 1'b1);
		`CHK({link_fault_trip, output_shutoff, minor_alarm_output}, 3'b111)
		@(posedge clk);
		drive_reset_input <= 1'b1;
		repeat (4) @(posedge clk);
		drive_reset_input <= 1'b0;
		xfer(INS_MODE_RD, 16'h0, 4'h0, 1'b0, 1'b1);
		xfer(INS_MODE_RD, 16'h0, 4'h0, 1'b0, 1'b0);
		xfer(INS_MODE_RD, 16'h0, 4'h0, 1'b0, 1'b1);
		`CHK(link_fault_trip, 1'b0)
	endtask : t_retry
	// limit 9999: alarm only, low-active terminal
	task automatic t_alarm();
		apb(1, A_RETRY, 32'h0000270f);
		apb(1, A_CFG, 32'h0000c600);
		repeat (2) @(negedge clk);
		`CHK(minor_alarm_output, 1'b1)
		xfer(INS_MODE_RD, 16'h0, 4'h0, 1'b0, 1'b1);
		`CHK({link_fault_trip, minor_alarm_output}, 2'b00)
		apb(1, A_CLEAR, 1);
		apb(1, A_CFG, 32'h00006200);
	endtask : t_alarm
	// signal loss: start, refresh, trip, disabled, zero interval
	task automatic t_loss();
		apb(1, A_MODE, 1);
		apb(1, A_CHECK, 1);
		apb(1, A_MODE, 0);
		repeat (1500) @(negedge clk);
		`CHK(link_fault_trip, 1'b0)
		repeat (3) begin
			xfer(INS_MODE_RD, 16'h0, 4'h0, 1'b0, 1'b0);
			repeat (500) @(negedge clk);
		end
		`CHK(link_fault_trip, 1'b0)
		repeat (1100) @(negedge clk);
		`CHK({link_fault_trip, output_shutoff, minor_alarm_output}, 3'b111)
		apb(1, A_CHECK, 32'h0000270f);
		apb(1, A_CLEAR, 1);
		xfer(INS_MODE_RD, 16'h0, 4'h0, 1'b0, 1'b0);
		repeat (1500) @(negedge clk);
		`CHK(link_fault_trip, 1'b0)
		apb(1, A_MODE, 1);
		apb(1, A_CHECK, 0);
		xfer(INS_MODE_RD, 16'h0, 4'h0, 1'b0, 1'b0);
		`CHK({r.data, link_fault_trip}, {MCODE_EXT, 1'b0})
		apb(1, A_MODE, 0);
		repeat (3) @(negedge clk);
		`CHK(link_fault_trip, 1'b1)
	endtask : t_loss
	task automatic summarize();
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : summarize
	// watchdog against a hung handshake
	initial begin
		repeat (40000) @(posedge clk);
		err_count++;
		$display("[ERR] %0t timeout", $time);
		summarize();
	end
	// main sequence
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_reply();
		t_mode();
		t_retry();
		t_alarm();
		t_loss();
		summarize();
	end
endmodule : sls_top_bench
